//--- verilog/edspt_pkg.sv
package edspt_pkg;

    // clock and time base
    localparam int CLOCK_HZ = 40_000_000;
    localparam int TICK_MS = 1;
    localparam int CYCLES_PER_TICK = CLOCK_HZ / 1000 * TICK_MS;
    localparam logic [9:0] MS_PER_S = 10'h3e8;
    localparam logic [9:0] MS_PER_QUARTER = 10'h0fa;
    localparam logic [17:0] BLINK_HALF_MS = 18'h0_01f4;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PARENT_TIMEOUT = 8'h04;
    localparam logic [7:0] OFS_END_POLL = 8'h08;
    localparam logic [7:0] OFS_SLEEP_DUR = 8'h0c;
    localparam logic [7:0] OFS_AWAKE_POLL = 8'h10;
    localparam logic [7:0] OFS_STANDBY = 8'h14;
    localparam logic [7:0] OFS_REJOIN = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    // key banks: offset bits 7:4 pick the bank, bits 3:2 the word, word 0 is key bits 31:0
    localparam logic [3:0] BANK_LINK_KEY = 4'h2;
    localparam logic [3:0] BANK_NET_KEY = 4'h3;
    localparam logic [3:0] BANK_NEW_KEY = 4'h4;

    // control register fields
    localparam int CTRL_ROLE_LSB = 0;
    localparam int CTRL_SEC_BIT = 4;
    localparam int CTRL_IND_BIT = 5;
    localparam int CTRL_APPLY_BIT = 8;
    localparam int CTRL_KEY_UPDATE_BIT = 9;
    localparam int CTRL_KEY_SWITCH_BIT = 10;

    // status register fields
    localparam int STAT_ROLE_LSB = 0;
    localparam int STAT_STATE_LSB = 4;
    localparam int STAT_JOINED_BIT = 8;
    localparam int STAT_LINK_BIT = 9;
    localparam int STAT_NEW_KEY_BIT = 10;
    localparam int STAT_IND_BIT = 11;
    localparam int STAT_CHILD_LSB = 16;

    // values after reset
    localparam logic [7:0] PARENT_TIMEOUT_RST = 8'h3c;
    localparam logic [7:0] END_POLL_RST = 8'h05;
    localparam logic [7:0] SLEEP_DUR_RST = 8'h08;
    localparam logic [15:0] AWAKE_POLL_RST = 16'h0064;
    localparam logic [7:0] STANDBY_RST = 8'h05;
    localparam logic [7:0] REJOIN_RST = 8'h0a;
    localparam int KEY_W = 128;
    localparam logic [127:0] KEY_RST = {4{32'hffff_ffff}};

    typedef enum logic [2:0] {
        ROLE_NONE = 3'h0,
        ROLE_COORD = 3'h1,
        ROLE_ROUTER = 3'h2,
        ROLE_END = 3'h3,
        ROLE_SLEEPY = 3'h4
    } edspt_role_type;

    typedef enum logic [2:0] {
        ST_OFF = 3'h1,
        ST_AWAKE = 3'h2,
        ST_SLEEP = 3'h4
    } edspt_state_type;

endpackage

//--- verilog/edspt_ms_tick.sv
`timescale 1ns/1ps
module edspt_ms_tick #(
    parameter int CYCLES = edspt_pkg::CYCLES_PER_TICK
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    output logic o_tick
);
    import edspt_pkg::*;

    localparam int CW = $clog2(CYCLES);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count;

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            count <= '0;
            o_tick <= 1'b0;
        end else if (count == LAST) begin
            count <= '0;
            o_tick <= 1'b1;
        end else begin
            count <= count + 1'b1;
            o_tick <= 1'b0;
        end
    end

endmodule

//--- verilog/edspt_node_ctrl.sv
`timescale 1ns/1ps
module edspt_node_ctrl #(
    parameter int CYCLES_PER_MS = edspt_pkg::CYCLES_PER_TICK,
    parameter int CHILDREN = 4,
    parameter int IDX_W = $clog2(CHILDREN)
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_wake_pin,
    input wire logic i_serial_rxd,
    input wire logic i_serial_data,
    input wire logic i_radio_data,
    input wire logic i_joined,
    input wire logic i_parent_link_up,
    input wire logic i_child_join,
    input wire logic i_child_poll,
    input wire logic [IDX_W-1:0] i_child_index,
    input wire logic i_join_request,
    input wire logic [edspt_pkg::KEY_W-1:0] i_join_key,
    input wire logic i_key_update,
    input wire logic [edspt_pkg::KEY_W-1:0] i_key_update_value,
    input wire logic i_key_switch,
    output logic o_radio_on,
    output logic o_asleep,
    output logic o_poll_request,
    output logic o_rejoin_request,
    output logic [CHILDREN-1:0] o_child_active,
    output logic o_join_grant,
    output logic o_join_deny,
    output logic o_security_on,
    output logic [edspt_pkg::KEY_W-1:0] o_net_key,
    output logic o_key_distribute,
    output logic o_key_switch,
    output logic o_indicator
);
    import edspt_pkg::*;

    function automatic logic [17:0] to_ms(input logic [15:0] value, input logic [9:0] unit);
        return 18'(value * unit);
    endfunction

    function automatic logic reached(input logic tick, input logic [17:0] cnt, input logic [17:0] limit);
        return tick && ((cnt + 18'h0_0001) >= limit);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = dat[b*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    logic ms_tick;
    logic [2:0] role_pending;
    logic [2:0] role_active;
    logic ind_enable;
    logic apply;
    logic sw_switch;
    logic [7:0] parent_timeout;
    logic [7:0] end_poll;
    logic [7:0] sleep_dur;
    logic [15:0] awake_poll;
    logic [7:0] standby;
    logic [7:0] rejoin;
    logic [KEY_W-1:0] link_key;
    logic [KEY_W-1:0] new_key;
    logic new_key_valid;
    edspt_state_type state;
    logic [17:0] poll_cnt;
    logic [17:0] standby_cnt;
    logic [17:0] sleep_cnt;
    logic [17:0] rejoin_cnt;
    logic [17:0] blink_cnt;
    logic [17:0] child_cnt [CHILDREN];
    logic wake_meta;
    logic wake_sync;
    logic wake_last;
    logic rxd_meta;
    logic rxd_sync;
    logic rxd_last;
    logic [31:0] next_rdat;

    edspt_ms_tick #(
        .CYCLES(CYCLES_PER_MS)
    ) u_tick (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .o_tick(ms_tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // wishbone decode
    wire logic bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire logic wr = bus_req && i_wb_we;
    wire logic [7:0] offset = {i_wb_adr[7:2], 2'b00};
    wire logic [3:0] bank = i_wb_adr[7:4];
    wire logic [1:0] word = i_wb_adr[3:2];

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= bus_req;
            o_wb_dat <= (bus_req && !i_wb_we) ? next_rdat : 32'h0000_0000;
        end
    end

    always_comb begin
        next_rdat = 32'h0000_0000;
        if (bank == BANK_LINK_KEY) begin
            next_rdat = link_key[word*32 +: 32];
        end else if (bank == BANK_NET_KEY) begin
            next_rdat = o_net_key[word*32 +: 32];
        end else if (bank == BANK_NEW_KEY) begin
            next_rdat = new_key[word*32 +: 32];
        end else begin
            case (offset)
                OFS_CTRL: begin
                    next_rdat[CTRL_ROLE_LSB +: 3] = role_pending;
                    next_rdat[CTRL_SEC_BIT] = o_security_on;
                    next_rdat[CTRL_IND_BIT] = ind_enable;
                end
                OFS_PARENT_TIMEOUT: next_rdat[7:0] = parent_timeout;
                OFS_END_POLL: next_rdat[7:0] = end_poll;
                OFS_SLEEP_DUR: next_rdat[7:0] = sleep_dur;
                OFS_AWAKE_POLL: next_rdat[15:0] = awake_poll;
                OFS_STANDBY: next_rdat[7:0] = standby;
                OFS_REJOIN: next_rdat[7:0] = rejoin;
                OFS_STATUS: begin
                    next_rdat[STAT_ROLE_LSB +: 3] = role_active;
                    next_rdat[STAT_STATE_LSB +: 3] = state;
                    next_rdat[STAT_JOINED_BIT] = i_joined;
                    next_rdat[STAT_LINK_BIT] = i_parent_link_up;
                    next_rdat[STAT_NEW_KEY_BIT] = new_key_valid;
                    next_rdat[STAT_IND_BIT] = o_indicator;
                    next_rdat[STAT_CHILD_LSB +: CHILDREN] = o_child_active;
                end
                default: next_rdat = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers; role changes only take hold through the apply command
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            role_pending <= ROLE_NONE;
            role_active <= ROLE_NONE;
            o_security_on <= 1'b0;
            ind_enable <= 1'b0;
            apply <= 1'b0;
            sw_switch <= 1'b0;
            o_key_distribute <= 1'b0;
            parent_timeout <= PARENT_TIMEOUT_RST;
            end_poll <= END_POLL_RST;
            sleep_dur <= SLEEP_DUR_RST;
            awake_poll <= AWAKE_POLL_RST;
            standby <= STANDBY_RST;
            rejoin <= REJOIN_RST;
            link_key <= KEY_RST;
        end else begin
            apply <= 1'b0;
            sw_switch <= 1'b0;
            o_key_distribute <= 1'b0;
            if (wr && bank == BANK_LINK_KEY) begin
                link_key[word*32 +: 32] <= merge(link_key[word*32 +: 32], i_wb_dat, i_wb_sel);
            end
            if (wr) begin
                case (offset)
                    OFS_CTRL: begin
                        if (i_wb_sel[0]) begin
                            role_pending <= i_wb_dat[CTRL_ROLE_LSB +: 3];
                            o_security_on <= i_wb_dat[CTRL_SEC_BIT];
                            ind_enable <= i_wb_dat[CTRL_IND_BIT];
                        end
                        if (i_wb_sel[1] && i_wb_dat[CTRL_APPLY_BIT]) begin
                            role_active <= i_wb_sel[0] ? i_wb_dat[CTRL_ROLE_LSB +: 3] : role_pending;
                            apply <= 1'b1;
                        end
                        if (i_wb_sel[1] && i_wb_dat[CTRL_KEY_UPDATE_BIT] && role_active == ROLE_COORD) begin
                            o_key_distribute <= 1'b1;
                        end
                        if (i_wb_sel[1] && i_wb_dat[CTRL_KEY_SWITCH_BIT]) begin
                            sw_switch <= 1'b1;
                        end
                    end
                    OFS_PARENT_TIMEOUT: if (i_wb_sel[0]) parent_timeout <= i_wb_dat[7:0];
                    OFS_END_POLL: if (i_wb_sel[0]) end_poll <= i_wb_dat[7:0];
                    OFS_SLEEP_DUR: if (i_wb_sel[0]) sleep_dur <= i_wb_dat[7:0];
                    OFS_AWAKE_POLL: awake_poll <= 16'(merge({16'h0000, awake_poll}, i_wb_dat, i_wb_sel));
                    OFS_STANDBY: if (i_wb_sel[0]) standby <= i_wb_dat[7:0];
                    OFS_REJOIN: if (i_wb_sel[0]) rejoin <= i_wb_dat[7:0];
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // wake pin and serial line are asynchronous pins
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            wake_meta <= 1'b1;
            wake_sync <= 1'b1;
            wake_last <= 1'b1;
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
            rxd_last <= 1'b1;
        end else begin
            wake_meta <= i_wake_pin;
            wake_sync <= wake_meta;
            wake_last <= wake_sync;
            rxd_meta <= i_serial_rxd;
            rxd_sync <= rxd_meta;
            rxd_last <= rxd_sync;
        end
    end

    wire logic wake_fall = wake_last && !wake_sync;
    // a start bit wakes the node; the byte it begins may be lost while the receiver comes up
    wire logic rxd_fall = rxd_last && !rxd_sync;
    wire logic is_end = role_active == ROLE_END;
    wire logic is_sleepy = role_active == ROLE_SLEEPY;
    wire logic is_parent = role_active == ROLE_COORD || role_active == ROLE_ROUTER;
    wire logic is_child = is_end || is_sleepy || role_active == ROLE_ROUTER;
    wire logic activity = i_serial_data || i_radio_data || rxd_fall;
    wire logic [17:0] poll_limit = is_sleepy ? to_ms(awake_poll, 10'h001) : to_ms({8'h00, end_poll}, MS_PER_S);
    wire logic poll_hit = reached(ms_tick, poll_cnt, poll_limit);
    wire logic standby_hit = reached(ms_tick, standby_cnt, to_ms({8'h00, standby}, MS_PER_S));
    wire logic sleep_hit = reached(ms_tick, sleep_cnt, to_ms({8'h00, sleep_dur}, MS_PER_QUARTER));
    wire logic rejoin_hit = reached(ms_tick, rejoin_cnt, to_ms({8'h00, rejoin}, MS_PER_S));
    wire logic blink_hit = reached(ms_tick, blink_cnt, BLINK_HALF_MS);
    wire logic [17:0] child_limit = to_ms({8'h00, parent_timeout}, MS_PER_S);

    ////////////////////////////////////////////////////////////////////////////////
    // sleep and wake sequencing
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            state <= ST_OFF;
        end else if (apply) begin
            state <= ST_OFF;
        end else begin
            unique case (state)
                ST_OFF: begin
                    if (i_joined && (is_end || is_sleepy)) begin
                        state <= ST_AWAKE;
                    end
                end
                ST_AWAKE: begin
                    if (!i_joined) begin
                        state <= ST_OFF;
                    end else if (is_sleepy && standby_hit && !activity) begin
                        state <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (sleep_hit || wake_fall || rxd_fall) begin
                        state <= ST_AWAKE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_radio_on <= 1'b1;
            o_asleep <= 1'b0;
        end else begin
            o_radio_on <= state != ST_SLEEP;
            o_asleep <= state == ST_SLEEP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // millisecond timers
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            poll_cnt <= 18'h0_0000;
            o_poll_request <= 1'b0;
        end else begin
            o_poll_request <= state == ST_AWAKE && poll_hit && !apply;
            if (state != ST_AWAKE || apply || poll_hit) begin
                poll_cnt <= 18'h0_0000;
            end else if (ms_tick) begin
                poll_cnt <= poll_cnt + 18'h0_0001;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            standby_cnt <= 18'h0_0000;
        end else if (state != ST_AWAKE || apply || activity || standby_hit) begin
            standby_cnt <= 18'h0_0000;
        end else if (ms_tick) begin
            standby_cnt <= standby_cnt + 18'h0_0001;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            sleep_cnt <= 18'h0_0000;
        end else if (state != ST_SLEEP || apply) begin
            sleep_cnt <= 18'h0_0000;
        end else if (ms_tick) begin
            sleep_cnt <= sleep_cnt + 18'h0_0001;
        end
    end

    // keeps asking every rejoin timeout for as long as the link stays down
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            rejoin_cnt <= 18'h0_0000;
            o_rejoin_request <= 1'b0;
        end else begin
            o_rejoin_request <= is_child && !i_parent_link_up && rejoin_hit && !apply;
            if (!is_child || i_parent_link_up || apply || rejoin_hit) begin
                rejoin_cnt <= 18'h0_0000;
            end else if (ms_tick) begin
                rejoin_cnt <= rejoin_cnt + 18'h0_0001;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            blink_cnt <= 18'h0_0000;
            o_indicator <= 1'b0;
        end else if (!(i_joined && ind_enable) || apply) begin
            blink_cnt <= 18'h0_0000;
            o_indicator <= 1'b0;
        end else if (blink_hit) begin
            blink_cnt <= 18'h0_0000;
            o_indicator <= !o_indicator;
        end else if (ms_tick) begin
            blink_cnt <= blink_cnt + 18'h0_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // child table: one silence counter per slot, cleared by each poll
    always_ff @(posedge i_clock) begin
        if (!i_resetn || apply || !is_parent) begin
            o_child_active <= '0;
            for (int i = 0; i < CHILDREN; i++) begin
                child_cnt[i] <= 18'h0_0000;
            end
        end else begin
            for (int i = 0; i < CHILDREN; i++) begin
                if ((i_child_join || i_child_poll) && i_child_index == IDX_W'(i)) begin
                    child_cnt[i] <= 18'h0_0000;
                    if (i_child_join) begin
                        o_child_active[i] <= 1'b1;
                    end
                end else if (reached(ms_tick, child_cnt[i], child_limit)) begin
                    o_child_active[i] <= 1'b0;
                    child_cnt[i] <= 18'h0_0000;
                end else if (ms_tick && o_child_active[i]) begin
                    child_cnt[i] <= child_cnt[i] + 18'h0_0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // keys and trust center check
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_join_grant <= 1'b0;
            o_join_deny <= 1'b0;
        end else begin
            o_join_grant <= i_join_request && role_active == ROLE_COORD && i_join_key == link_key;
            o_join_deny <= i_join_request && role_active == ROLE_COORD && i_join_key != link_key;
        end
    end

    // an update arriving with a switch becomes the next pending key, not the active one
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_net_key <= KEY_RST;
            new_key <= KEY_RST;
            new_key_valid <= 1'b0;
            o_key_switch <= 1'b0;
        end else begin
            o_key_switch <= sw_switch && role_active == ROLE_COORD;
            if (wr && bank == BANK_NET_KEY) begin
                o_net_key[word*32 +: 32] <= merge(o_net_key[word*32 +: 32], i_wb_dat, i_wb_sel);
            end else if ((i_key_switch || sw_switch) && new_key_valid) begin
                o_net_key <= new_key;
            end
            if ((i_key_switch || sw_switch) && new_key_valid) begin
                new_key_valid <= 1'b0;
            end
            if (i_key_update) begin
                new_key <= i_key_update_value;
                new_key_valid <= 1'b1;
            end else if (wr && bank == BANK_NEW_KEY) begin
                new_key[word*32 +: 32] <= merge(new_key[word*32 +: 32], i_wb_dat, i_wb_sel);
                new_key_valid <= 1'b1;
            end
        end
    end

endmodule

//--- tb/edspt_chk_sva.sv
`timescale 1ns/1ps
module edspt_chk (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic i_joined,
    input wire logic i_join_request,
    input wire logic i_key_switch,
    input wire logic o_wb_ack,
    input wire logic o_asleep,
    input wire logic o_radio_on,
    input wire logic o_poll_request,
    input wire logic o_join_grant,
    input wire logic o_join_deny,
    input wire logic [127:0] o_net_key,
    input wire logic o_indicator
);
default clocking @(posedge i_clock); endclocking
default disable iff (!i_resetn);
a_ack_pulse: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb) ##1 !o_wb_ack) else $error("bad ack");
a_sleep_radio: assert property (o_asleep |-> !o_radio_on) else $error("radio on asleep");
a_sleep_poll: assert property (o_asleep |-> !o_poll_request) else $error("poll asleep");
a_poll_pulse: assert property (o_poll_request |=> !o_poll_request) else $error("poll held");
a_join_cause: assert property (o_join_grant || o_join_deny |-> $past(i_join_request)) else $error("join");
a_join_excl: assert property (!(o_join_grant && o_join_deny)) else $error("grant and deny");
a_key_cause: assert property ($changed(o_net_key) |-> $past(i_key_switch || i_wb_stb && i_wb_we))
    else $error("key moved");
a_ind_idle: assert property (!i_joined [*3] |-> !o_indicator) else $error("blink unjoined");
endmodule
bind edspt_node_ctrl edspt_chk u_edspt_chk (.*);

//--- tb/edspt_parent.sv
`timescale 1ns/1ps
module edspt_parent #(
    parameter int DELAY = 3
) (
    input wire logic i_clock,
    input wire logic i_answer,
    input wire logic i_poll,
    input wire logic i_drop,
    output logic o_radio_data,
    output logic o_link_up
);
    logic [7:0] wait_cnt = 8'h00;
    // link loss is driven by the bench so the rejoin timer can be exercised
    assign o_link_up = !i_drop;
    // a parent answers each poll a few cycles later; silent when told not to
    always @(posedge i_clock) begin
        o_radio_data <= (wait_cnt == 8'h01);
        if (i_poll && i_answer) wait_cnt <= DELAY[7:0];
        else if (wait_cnt != 8'h00) wait_cnt <= wait_cnt - 8'h01;
    end
endmodule

//--- tb/tb_edspt_node_ctrl.sv
`timescale 1ns/1ps
module tb_edspt_node_ctrl;
import edspt_pkg::*;
logic clk = 0, rstn = 0, req = 0, we = 0, wake = 1, rxd = 1, sd = 0, jn = 0, jr = 0, ku = 0, ks = 0, ans = 0;
logic cj = 0, cp = 0, drop = 0;
logic ack, slp, poll, rdat, link, gr, dn, ind, sec, rej;
logic [3:0] act;
logic [7:0] adr = 0;
logic [31:0] wd = 0, od, rd;
logic [127:0] jk = 0, kv = 0, key;
int miscompares = 0, num_checks = 0, cycles = 0;
edspt_node_ctrl #(.CYCLES_PER_MS(4)) u_edspt_node_ctrl (.i_clock(clk), .i_resetn(rstn), .i_wb_cyc(req),
    .i_wb_stb(req), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wd), .i_wb_sel(4'hf), .o_wb_dat(od), .o_wb_ack(ack),
    .i_wake_pin(wake), .i_serial_rxd(rxd), .i_serial_data(sd), .i_radio_data(rdat), .i_joined(jn),
    .i_parent_link_up(link), .i_child_join(cj), .i_child_poll(cp), .i_child_index(2'h1), .i_join_request(jr),
    .i_join_key(jk), .i_key_update(ku), .i_key_update_value(kv), .i_key_switch(ks), .o_radio_on(), .o_asleep(slp),
    .o_poll_request(poll), .o_rejoin_request(rej), .o_child_active(act), .o_join_grant(gr), .o_join_deny(dn),
    .o_security_on(sec), .o_net_key(key), .o_key_distribute(), .o_key_switch(), .o_indicator(ind));
edspt_parent u_edspt_parent (.i_clock(clk), .i_answer(ans), .i_poll(poll), .i_drop(drop), .o_radio_data(rdat),
    .o_link_up(link));
always #12.5 clk = ~clk;
task automatic chk(input logic [127:0] g, input logic [127:0] e);
    num_checks++;
    if (g !== e) begin
        miscompares++;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
endtask
task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (ack !== 1'h1);
    rd = od;
    req <= 0;
    @(posedge clk);
endtask
task automatic apply(input logic [2:0] r);
    wb(1, OFS_CTRL, 32'h0000_0100 | r);
    wb(0, OFS_STATUS, 0);
    chk(rd[2:0], r);
endtask
// s: 0 next poll, 1 asleep, 2 awake, 3 indicator on, 4 indicator off, 5 rejoin request
task automatic cnt(input int s, output int n);
    n = 0;
    do begin
        @(negedge clk);
        n++;
    end while ((s == 0 ? poll : s == 1 ? slp : s == 2 ? !slp : s == 3 ? ind : s == 4 ? !ind : rej) !== 1'h1);
    @(posedge clk);
endtask
task automatic end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
task automatic t_regs;
    int e[6] = '{60, 5, 8, 100, 5, 10};
    for (int i = 0; i < 6; i++) begin
        wb(0, OFS_PARENT_TIMEOUT + 8'(4 * i), 0);
        chk(rd, e[i]);
    end
    wb(0, 8'hfc, 0);
    chk(rd, 0);
    wb(0, 8'h30, 0);
    chk(rd, 32'hffff_ffff);
    $display("regs done");
endtask
task automatic t_end;
    int n;
    jn <= 1;
    ans <= 1;
    wb(1, OFS_END_POLL, 1);
    wb(1, OFS_REJOIN, 1);
    apply(3);
    cnt(0, n);
    cnt(0, n);
    chk(n, 4000);
    chk(slp, 0);
    drop <= 1;
    cnt(5, n);
    cnt(5, n);
    chk(n, 4000);
    drop <= 0;
    $display("end node done");
endtask
task automatic t_sleepy;
    int n;
    ans <= 0;
    wb(1, OFS_STANDBY, 1);
    wb(1, OFS_SLEEP_DUR, 1);
    apply(4);
    cnt(0, n);
    cnt(0, n);
    chk(n, 400);
    cnt(1, n);
    cnt(2, n);
    chk(n > 994 && n < 1004, 1);
    repeat (3000) @(posedge clk);
    sd <= 1;
    @(posedge clk);
    sd <= 0;
    cnt(1, n);
    chk(n > 3994 && n < 4006, 1);
    $display("sleepy done");
endtask
task automatic t_wake;
    int n;
    wake <= 0;
    cnt(2, n);
    chk(n < 8, 1);
    wake <= 1;
    cnt(1, n);
    rxd <= 0;
    cnt(2, n);
    chk(n < 8, 1);
    rxd <= 1;
    $display("wake done");
endtask
task automatic t_parent;
    apply(1);
    wb(1, OFS_PARENT_TIMEOUT, 1);
    cj <= 1;
    @(posedge clk);
    cj <= 0;
    repeat (3000) @(posedge clk);
    chk(act, 4'h2);
    cp <= 1;
    @(posedge clk);
    cp <= 0;
    repeat (3990) @(posedge clk);
    chk(act, 4'h2);
    repeat (20) @(posedge clk);
    chk(act, 4'h0);
    $display("parent done");
endtask
task automatic t_ind;
    int n;
    wb(1, OFS_CTRL, 32'h0000_0031);
    chk(sec, 1);
    cnt(3, n);
    cnt(4, n);
    chk(n, 2000);
    jn <= 0;
    repeat (4) @(posedge clk);
    chk(ind, 0);
    $display("indicator done");
endtask
task automatic t_keys;
    for (int i = 0; i < 2; i++) begin
        jr <= 1;
        jk <= {128{1'h1}} ^ 128'(i);
        @(posedge clk);
        jr <= 0;
        @(negedge clk);
        chk({gr, dn}, i ? 2'h1 : 2'h2);
        @(posedge clk);
    end
    ku <= 1;
    kv <= 128'h1234;
    @(posedge clk);
    ku <= 0;
    @(posedge clk);
    chk(key, {128{1'h1}});
    ks <= 1;
    @(posedge clk);
    ks <= 0;
    @(negedge clk);
    chk(key, 128'h1234);
    $display("keys done");
endtask
initial begin
    repeat (12) @(posedge clk);
    rstn <= 1;
    t_regs;
    t_end;
    t_sleepy;
    t_wake;
    t_parent;
    t_ind;
    t_keys;
    end_sim;
end
always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
        miscompares++;
        end_sim;
    end
end
endmodule
